/* File: dual_half_mul.sv */
// two signed 16x16 products with optional halfword swap
`timescale 1ns/100ps
`include "mac_defs.svh"

module dual_half_mul (
	input  wire logic        [31:0] first_operand_i,
	input  wire logic        [31:0] second_operand_i,
	input  wire logic               swap_i,
	output logic signed      [31:0] prod_lo_o,
	output logic signed      [31:0] prod_hi_o
);
	logic [31:0] m_sel;

	// swap pairs bottom with top and top with bottom
	assign m_sel = swap_i ? {second_operand_i[`MAC_HALF_LO], second_operand_i[`MAC_HALF_HI]}
	                      : second_operand_i; // RQ1

	// a 16x16 signed product always fits in 32 bits
	assign prod_lo_o = $signed(first_operand_i[`MAC_HALF_LO]) * $signed(m_sel[`MAC_HALF_LO]);
	assign prod_hi_o = $signed(first_operand_i[`MAC_HALF_HI]) * $signed(m_sel[`MAC_HALF_HI]);
endmodule

/* File: mac_checker.sv */
// assertions on the multiply datapath ports
`timescale 1ns/100ps
module mac_checker (
	input wire logic              clk_i,
	input wire logic              srst_i,
	input wire logic              req_valid_i,
	input wire mac_pkg::mac_req_s req_i,
	input wire logic              sticky_clear_i,
	input wire logic              res_valid_o,
	input wire mac_pkg::mac_res_s res_o,
	input wire logic              sticky_ovfl_flag_o,
	input wire logic              flags_write_o
);
	import mac_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence s_long; req_valid_i && req_i.op == OP_DUAL_MUL_DIFF_ACC_LONG; endsequence
	sequence s_top; req_valid_i && req_i.op inside
		{OP_TOP_WORD_MUL, OP_TOP_WORD_MUL_ACC, OP_TOP_WORD_MUL_SUB}; endsequence
	property p_lat; req_valid_i |-> ##2 res_valid_o; endproperty
	a_lat: assert property (p_lat) else $error("late");
	property p_quiet; !req_valid_i |-> ##2 !res_valid_o; endproperty
	a_quiet: assert property (p_quiet) else $error("extra");
	property p_set; $rose(sticky_ovfl_flag_o) |-> res_valid_o && res_o.ovfl; endproperty
	a_set: assert property (p_set) else $error("set");
	property p_keep; $fell(sticky_ovfl_flag_o) |-> $past(sticky_clear_i) || $past(srst_i); endproperty
	a_keep: assert property (p_keep) else $error("keep");
	property p_hold; res_valid_o && res_o.ovfl |-> sticky_ovfl_flag_o; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_flags; !flags_write_o; endproperty
	a_flags: assert property (p_flags) else $error("flags");
	property p_long; s_long |-> ##2 res_o.is_long && !res_o.ovfl; endproperty
	a_long: assert property (p_long) else $error("long");
	property p_top; s_top |-> ##2 !res_o.ovfl; endproperty
	a_top: assert property (p_top) else $error("top");
endmodule
bind signed_dual_and_top_word_mac mac_checker chk_u (.clk_i, .srst_i, .req_valid_i, .req_i,
	.sticky_clear_i, .res_valid_o, .res_o, .sticky_ovfl_flag_o, .flags_write_o);

/* File: mac_defs.svh */
// constants for the signed dual and top-word multiply datapath
`ifndef MAC_DEFS_SVH
`define MAC_DEFS_SVH

`define MAC_ROUND_BIAS   64'h0000_0000_8000_0000
`define MAC_HALF_LO      15:0
`define MAC_HALF_HI      31:16
`define MAC_FLAG_RESET   1'b0
`define MAC_LATENCY      2

`endif

/* File: mac_issuer.sv */
// decode and register file model issuing requests
`timescale 1ns/100ps
module mac_issuer (
	input  wire logic              clk_i,
	input  wire logic              go_i,
	input  wire mac_pkg::mac_req_s req_in_i,
	output logic                   req_valid_o,
	output mac_pkg::mac_req_s      req_o
);
	import mac_pkg::*;
	initial req_valid_o = 1'b0;
	initial req_o = '0;
	// idle fields inverted each cycle, so every second idle cycle repeats the stale copy
	always @(posedge clk_i) begin
		req_valid_o <= go_i;
		req_o <= go_i ? req_in_i : ~req_o;
	end
endmodule

/* File: mac_pkg.sv */
// types for the signed dual and top-word multiply datapath
package mac_pkg;

	typedef enum logic [3:0] {
		OP_DUAL_MUL_ADD,
		OP_DUAL_MUL_DIFF,
		OP_DUAL_MUL_DIFF_ACC,
		OP_DUAL_MUL_DIFF_ACC_LONG,
		OP_TOP_WORD_MUL,
		OP_TOP_WORD_MUL_ACC,
		OP_TOP_WORD_MUL_SUB
	} mac_op_e;

	typedef struct packed {
		mac_op_e     op;
		logic        halfword_swap;
		logic        half_bias_add_on;
		logic [31:0] first_operand;
		logic [31:0] second_operand;
		logic [31:0] accum_input;
		logic [31:0] accum_high_word;
		logic [31:0] accum_low_word;
	} mac_req_s;

	typedef struct packed {
		logic [31:0] dest_word;
		logic [31:0] accum_high_word;
		logic [31:0] accum_low_word;
		logic        is_long;
		logic        ovfl;
	} mac_res_s;

endpackage

/* File: signed_dual_and_top_word_mac.sv */
// signed dual halfword and top-word multiply datapath
`timescale 1ns/100ps
`include "mac_defs.svh"

// Summary of operation
// RQ1: swap option pairs bottom-top and top-bottom halfwords
// RQ2: diff acc: low minus high product plus accum
// RQ3: long diff acc: difference plus 64-bit pair
// RQ4: flag sticky overflow on diff-acc accumulate step
// RQ5: top-word acc: high product word plus accum
// RQ6: top-word sub: accum minus high product word
// RQ7: rounding adds 0x80000000 before taking high word
// RQ8: top-word mul writes signed high product word
// RQ9: top-word operations leave condition flags untouched
// RQ10: dual add: sum of two halfword products
// RQ11: dual diff: bottom product minus top product
// RQ12: flag sticky overflow on dual add sum
// RQ13: issuer never names stack or program counter
// RQ14: sticky flag is status word saturation bit
// RQ15: operations only set sticky flag, never clear
module signed_dual_and_top_word_mac (
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic              req_valid_i,
	input  wire mac_pkg::mac_req_s req_i,
	input  wire logic              sticky_clear_i,
	output logic                   res_valid_o,
	output mac_pkg::mac_res_s      res_o,
	output logic                   sticky_ovfl_flag_o,
	output logic                   flags_write_o
);
	import mac_pkg::*;

	// ---------------------------------------------------------------
	// stage one: products
	// ---------------------------------------------------------------
	logic signed [31:0] prod_lo;
	logic signed [31:0] prod_hi;
	logic signed [63:0] word_prod;
	logic signed [63:0] word_prod_b;
	logic               s1_valid_q;
	mac_req_s           s1_req_q;
	logic signed [31:0] s1_lo_q;
	logic signed [31:0] s1_hi_q;
	logic signed [63:0] s1_word_q;

	// operands from RQ13-clean register numbers only; no special cases here
	dual_half_mul u_dual (
		.first_operand_i  (req_i.first_operand),
		.second_operand_i (req_i.second_operand),
		.swap_i           (req_i.halfword_swap),
		.prod_lo_o        (prod_lo),
		.prod_hi_o        (prod_hi)
	);

	// ---------------------------------------------------------------
	// stage one: top-word product and rounding bias
	// ---------------------------------------------------------------
	logic signed [31:0] word_a;
	logic signed [31:0] word_b;
	logic signed [63:0] round_bias;

	assign word_a      = req_i.first_operand;
	assign word_b      = req_i.second_operand;
	assign word_prod   = word_a * word_b; // RQ8
	// bias only when rounding; its carry into the high word does the rounding
	assign round_bias  = req_i.half_bias_add_on ? `MAC_ROUND_BIAS : 64'h0; // RQ7
	assign word_prod_b = word_prod + round_bias; // RQ7

	// ---------------------------------------------------------------
	// stage one: pipeline registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s1_valid_q <= 1'b0;
		end else begin
			s1_valid_q <= req_valid_i;
		end
	end

	// datapath registers carry no reset; valid qualifies them
	always_ff @(posedge clk_i) begin
		s1_req_q <= req_i;
	end

	always_ff @(posedge clk_i) begin
		s1_lo_q <= prod_lo;
		s1_hi_q <= prod_hi;
	end

	always_ff @(posedge clk_i) begin
		s1_word_q <= word_prod_b;
	end

	// ---------------------------------------------------------------
	// stage two: operation decode
	// ---------------------------------------------------------------
	logic cls_dual_add;
	logic cls_dual_diff;
	logic cls_diff_acc;
	logic cls_diff_long;
	logic cls_top_mul;
	logic cls_top_acc;
	logic cls_top_sub;
	logic cls_top_any;
	logic cls_dual_word;

	// codes outside the list select nothing: result zero, no flag
	always_comb begin
		cls_dual_add  = 1'b0;
		cls_dual_diff = 1'b0;
		cls_diff_acc  = 1'b0;
		cls_diff_long = 1'b0;
		cls_top_mul   = 1'b0;
		cls_top_acc   = 1'b0;
		cls_top_sub   = 1'b0;
		case (s1_req_q.op)
			OP_DUAL_MUL_ADD: begin
				cls_dual_add = 1'b1;
			end
			OP_DUAL_MUL_DIFF: begin
				cls_dual_diff = 1'b1;
			end
			OP_DUAL_MUL_DIFF_ACC: begin
				cls_diff_acc = 1'b1;
			end
			OP_DUAL_MUL_DIFF_ACC_LONG: begin
				cls_diff_long = 1'b1;
			end
			OP_TOP_WORD_MUL: begin
				cls_top_mul = 1'b1;
			end
			OP_TOP_WORD_MUL_ACC: begin
				cls_top_acc = 1'b1;
			end
			OP_TOP_WORD_MUL_SUB: begin
				cls_top_sub = 1'b1;
			end
			default: begin
				cls_dual_add  = 1'b0;
				cls_dual_diff = 1'b0;
				cls_diff_acc  = 1'b0;
				cls_diff_long = 1'b0;
				cls_top_mul   = 1'b0;
				cls_top_acc   = 1'b0;
				cls_top_sub   = 1'b0;
			end
		endcase
	end

	assign cls_top_any   = cls_top_mul | cls_top_acc | cls_top_sub;
	assign cls_dual_word = cls_dual_add | cls_dual_diff | cls_diff_acc;

	// ---------------------------------------------------------------
	// stage two: dual halfword arithmetic
	// ---------------------------------------------------------------
	logic signed [32:0] pair_sum;
	logic signed [32:0] pair_diff;
	logic signed [33:0] diff_acc;
	logic               sum_ovfl;
	logic               acc_ovfl;
	logic        [31:0] dual_word;

	// 33-bit forms expose overflow of the 32-bit result
	assign pair_sum  = 33'(s1_lo_q) + 33'(s1_hi_q);
	assign pair_diff = 33'(s1_lo_q) - 33'(s1_hi_q);
	assign diff_acc  = 34'(pair_diff) + 34'($signed(s1_req_q.accum_input));
	assign sum_ovfl  = pair_sum[32] != pair_sum[31]; // RQ12
	assign acc_ovfl  = diff_acc[33:31] != {3{diff_acc[31]}}; // RQ4

	always_comb begin
		dual_word = '0;
		case (s1_req_q.op)
			OP_DUAL_MUL_ADD: begin
				dual_word = pair_sum[31:0]; // RQ10
			end
			OP_DUAL_MUL_DIFF: begin
				// difference of two 16x16 products cannot leave 32 bits
				dual_word = pair_diff[31:0]; // RQ11
			end
			OP_DUAL_MUL_DIFF_ACC: begin
				dual_word = diff_acc[31:0]; // RQ2
			end
			default: begin
				dual_word = '0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// stage two: long accumulate
	// ---------------------------------------------------------------
	logic signed [63:0] long_base;
	logic signed [63:0] long_acc;
	logic        [31:0] long_hi_word;
	logic        [31:0] long_lo_word;

	// the long pair wraps; it has no overflow to report
	assign long_base    = $signed({s1_req_q.accum_high_word, s1_req_q.accum_low_word});
	assign long_acc     = 64'(pair_diff) + long_base; // RQ3
	assign long_hi_word = long_acc[63:32]; // RQ3
	assign long_lo_word = long_acc[31:0]; // RQ3

	// ---------------------------------------------------------------
	// stage two: top-word arithmetic
	// ---------------------------------------------------------------
	logic signed [31:0] top_word;
	logic        [31:0] top_acc_word;
	logic        [31:0] top_sub_word;
	logic        [31:0] top_result;

	assign top_word     = s1_word_q[63:32]; // RQ8
	// wraps modulo 2^32, no flag effect
	assign top_acc_word = s1_req_q.accum_input + top_word; // RQ5
	assign top_sub_word = s1_req_q.accum_input - top_word; // RQ6

	always_comb begin
		top_result = '0;
		case (s1_req_q.op)
			OP_TOP_WORD_MUL: begin
				top_result = top_word; // RQ8
			end
			OP_TOP_WORD_MUL_ACC: begin
				top_result = top_acc_word; // RQ5
			end
			OP_TOP_WORD_MUL_SUB: begin
				top_result = top_sub_word; // RQ6
			end
			default: begin
				top_result = '0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// stage two: result assembly
	// ---------------------------------------------------------------
	mac_res_s res_d;
	logic     ovfl_d;

	// top-word and long ops never raise the flag
	assign ovfl_d = (cls_dual_add & sum_ovfl) | (cls_diff_acc & acc_ovfl); // RQ9

	always_comb begin
		res_d = '0;
		if (cls_diff_long) begin
			res_d.is_long         = 1'b1;
			res_d.accum_high_word = long_hi_word; // RQ3
			res_d.accum_low_word  = long_lo_word; // RQ3
		end else if (cls_top_any) begin
			res_d.dest_word = top_result;
		end else if (cls_dual_word) begin
			res_d.dest_word = dual_word;
		end
		res_d.ovfl = ovfl_d;
	end

	// ---------------------------------------------------------------
	// result outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			res_valid_o <= 1'b0;
		end else begin
			res_valid_o <= s1_valid_q;
		end
	end

	// last result stays visible until the next one lands
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			res_o <= '0;
		end else if (s1_valid_q) begin
			res_o <= res_d;
		end
	end

	// ---------------------------------------------------------------
	// condition codes and sticky saturation bit
	// ---------------------------------------------------------------
	// none of these operations write N, Z, C or V
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			flags_write_o <= 1'b0;
		end else begin
			flags_write_o <= 1'b0; // RQ9
		end
	end

	logic sticky_set;
	logic sticky_clr;

	// a set in the clear cycle wins, so no overflow is lost
	assign sticky_set = s1_valid_q & ovfl_d; // RQ15
	assign sticky_clr = sticky_clear_i & ~sticky_set;

	// saturation bit of the status word
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sticky_ovfl_flag_o <= `MAC_FLAG_RESET;
		end else if (sticky_set) begin
			sticky_ovfl_flag_o <= 1'b1; // RQ14
		end else if (sticky_clr) begin
			sticky_ovfl_flag_o <= 1'b0;
		end
	end
endmodule

/* File: signed_dual_and_top_word_mac_tb.sv */
// testbench for the multiply datapath
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch %0t %h %h", $time, g, e); end end
module signed_dual_and_top_word_mac_tb;
	import mac_pkg::*;
	localparam logic [31:0] A = 32'h0003_0002, B = 32'h0005_0004, H = 32'h0001_0000;
	localparam logic [31:0] G = 32'h0000_8000, Z = 32'h0;
	localparam logic [63:0] Q = 64'h0;
	localparam logic N = 1'b0, Y = 1'b1;
	int compares = 0, miscompares = 0;
	logic clk_i = 0, srst_i = 1, go = 0, clr = 0, rvi, rv, st, fw;
	mac_req_s rq = '0, req;
	mac_res_s res;
	always #4 clk_i = ~clk_i;
	mac_issuer iss_u (.clk_i, .go_i(go), .req_in_i(rq), .req_valid_o(rvi), .req_o(req));
	signed_dual_and_top_word_mac dut_u (.clk_i, .srst_i, .req_valid_i(rvi), .req_i(req),
		.sticky_clear_i(clr), .res_valid_o(rv), .res_o(res), .sticky_ovfl_flag_o(st),
		.flags_write_o(fw));
	task report_and_stop;
		if (miscompares == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// m: swap, bias
	task run(mac_op_e op, logic [1:0] m, logic [31:0] a, b, c, logic [63:0] hl, e, logic es);
		int n;
		@(posedge clk_i);
		rq <= '{op, m[1], m[0], a, b, c, hl[63:32], hl[31:0]};
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		for (n = 0; n < 8 && rv !== 1'b1; n++) @(negedge clk_i);
		if (n == 8) begin
			miscompares++;
			report_and_stop;
		end
		`CHK(res.is_long ? {res.accum_high_word, res.accum_low_word} : {Z, res.dest_word}, e)
		`CHK({st, fw}, {es, N})
	endtask
	task t_dual;
		run(OP_DUAL_MUL_ADD, 2'h0, A, B, Z, Q, 64'h17, N);
		run(OP_DUAL_MUL_ADD, 2'h2, A, B, Z, Q, 64'h16, N);
		run(OP_DUAL_MUL_DIFF, 2'h0, A, B, Z, Q, 64'hFFFF_FFF9, N);
		run(OP_DUAL_MUL_DIFF, 2'h2, A, B, Z, Q, 64'hFFFF_FFFE, N);
	endtask
	task t_acc;
		run(OP_DUAL_MUL_DIFF_ACC, 2'h0, A, B, 32'h10, Q, 64'h9, N);
		run(OP_DUAL_MUL_DIFF_ACC_LONG, 2'h0, A, B, Z, 64'h1_0000_0000, 64'hFFFF_FFF9, N);
		run(OP_DUAL_MUL_DIFF_ACC_LONG, 2'h2, A, B, Z, Q, 64'hFFFF_FFFF_FFFF_FFFE, N);
	endtask
	task t_top;
		run(OP_TOP_WORD_MUL, 2'h0, 32'h4000_0000, 32'h4000_0000, Z, Q, 64'h1000_0000, N);
		run(OP_TOP_WORD_MUL, 2'h0, H, G, Z, Q, Q, N);
		run(OP_TOP_WORD_MUL, 2'h1, H, G, Z, Q, 64'h1, N);
		run(OP_TOP_WORD_MUL, 2'h1, 32'hFFFF_FFFF, 32'h1, Z, Q, Q, N);
		run(OP_TOP_WORD_MUL_ACC, 2'h1, H, G, 32'h5, Q, 64'h6, N);
		run(OP_TOP_WORD_MUL_SUB, 2'h1, H, G, 32'h5, Q, 64'h4, N);
	endtask
	task t_sticky;
		run(OP_DUAL_MUL_ADD, 2'h0, 32'h8000_8000, 32'h8000_8000, Z, Q, 64'h8000_0000, Y);
		run(OP_TOP_WORD_MUL_ACC, 2'h0, Z, Z, 32'h7FFF_FFFF, Q, 64'h7FFF_FFFF, Y);
		@(posedge clk_i);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		@(negedge clk_i);
		`CHK(st, N)
		run(OP_DUAL_MUL_DIFF_ACC, 2'h0, 32'h2, 32'h4, 32'h7FFF_FFFF, Q, 64'h8000_0007, Y);
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		t_dual;
		t_acc;
		t_top;
		t_sticky;
		report_and_stop;
	end
endmodule
